// File: logic/mrcr_regs.sv
// Notes on behaviour
// - action code 1 resets module, 2 saves configuration, 3 restores factory set
// - all switches zero: address and baud from store, else from switches
// - firmware file present at power-up: update, stored configuration left alone
// - failure indicator flashes during a firmware update
// - failure indicator lit while any failure event is active, outside a firmware update
// - receive and transmit indicators blink with link frames
// - digital-output indicator follows the relay output
// - power indicator lit while supply is present
// - parameters readable and writable over the holding-register port
// - three log-name words, 16 bits, read-write, reset to zero
// - baud code 0..7 means 1200..115200, default 3
// - stored address word: address high byte, parity bits 1:0, stop bit 2
`timescale 1ns/1ns
module mrcr_regs #(
   parameter longint SEC_CYCLES   = mrcr_pkg::SEC_CYC,      // cycles per second
   parameter longint FLASH_CYCLES = mrcr_pkg::FLASH_CYC,    // half period of fail flash
   parameter longint HOLD_CYCLES  = mrcr_pkg::ACT_HOLD_CYC  // activity lamp on-time
)(
   input  wire logic                        clk_in,           // 100 MHz clock
   input  wire logic                        rst_n_in,         // async reset, low
   input  wire logic                        reg_req_in,       // register access request
   input  wire logic                        reg_we_in,        // 1 write, 0 read
   input  wire logic [15:0]                 reg_addr_in,      // holding-register address
   input  wire logic [15:0]                 reg_wdata_in,     // write data
   output logic                             reg_ack_out,      // answer pulse
   output logic                             reg_err_out,      // illegal address or busy
   output logic [15:0]                      reg_rdata_out,    // read data
   input  wire logic [mrcr_pkg::SW_W-1:0]   dip_sw_in,        // front switches, async
   input  wire logic [15:0]                 nv_addr_word_in,  // stored address word
   input  wire logic [2:0]                  nv_baud_in,       // stored baud code
   output mrcr_pkg::mrcr_link_s             link_cfg_out,     // chosen link settings
   input  wire logic                        fw_present_in,    // pen drive file, async
   input  wire logic                        fw_done_in,       // loader finished
   output logic                             fw_update_out,    // update in progress
   output logic                             reset_req_out,    // action reset pulse
   output logic                             save_cfg_out,     // action save pulse
   output logic                             factory_cfg_out,  // action factory pulse
   output logic [15:0]                      act_arg_a_out,    // latched argument a
   output logic [15:0]                      act_arg_b_out,    // latched argument b
   input  wire logic                        rx_frame_in,      // frame received pulse
   input  wire logic                        tx_frame_in,      // frame sent pulse
   input  wire logic [7:0]                  fail_events_in,   // failure event levels
   input  wire logic                        relay_on_in,      // relay output level
   output logic                             led_power_out,    // power lamp
   output logic                             led_fail_out,     // failure lamp
   output logic                             led_rx_out,       // receive lamp
   output logic                             led_tx_out,       // transmit lamp
   output logic                             led_dout_out      // digital output lamp
);
   localparam logic [31:0] SEC_LAST   = 32'(SEC_CYCLES - 1);
   localparam logic [31:0] FLASH_LAST = 32'(FLASH_CYCLES - 1);
   localparam logic [31:0] HOLD_LAST  = 32'(HOLD_CYCLES - 1);

   // days in a month; every fourth year in 2000..2099 is a leap year
   function automatic logic [7:0] mrcr_days(input logic [7:0] m, input logic [15:0] y);
      logic [7:0] d;
      d = 8'h1F;
      case (m)
         8'h04, 8'h06, 8'h09, 8'h0B: d = 8'h1E;
         8'h02:                      d = (y[1:0] == 2'h0) ? 8'h1D : 8'h1C;
         default:                    d = 8'h1F;
      endcase
      return d;
   endfunction : mrcr_days

   // three-stage synchronisers on the switch and pen drive pins
   logic [mrcr_pkg::SW_W-1:0] sw_s1_r, sw_s2_r, sw_s3_r, sw_q_r, sw_q_nxt;
   logic                      fw_s1_r, fw_s2_r, fw_s3_r, fw_q_r, fw_q_nxt;

   always_comb
   begin
      sw_q_nxt = (sw_s2_r == sw_s3_r) ? sw_s3_r : sw_q_r;
      fw_q_nxt = (fw_s2_r == fw_s3_r) ? fw_s3_r : fw_q_r;
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         sw_s1_r <= '0;
         sw_s2_r <= '0;
         sw_s3_r <= '0;
         sw_q_r  <= '0;
         fw_s1_r <= 1'b0;
         fw_s2_r <= 1'b0;
         fw_s3_r <= 1'b0;
         fw_q_r  <= 1'b0;
      end
      else
      begin
         sw_s1_r <= dip_sw_in;
         sw_s2_r <= sw_s1_r;
         sw_s3_r <= sw_s2_r;
         sw_q_r  <= sw_q_nxt;
         fw_s1_r <= fw_present_in;
         fw_s2_r <= fw_s1_r;
         fw_s3_r <= fw_s2_r;
         fw_q_r  <= fw_q_nxt;
      end
   end

   // link settings: stored word when switches all read zero, else the switches
   mrcr_pkg::mrcr_link_s link_nxt, link_r;
   logic [7:0]           sw_addr;

   always_comb
   begin
      sw_addr  = {2'h0, sw_q_r[mrcr_pkg::SW_BAUD_LSB-1:0]};
      link_nxt = link_r;
      if (sw_q_r == '0)
      begin
         link_nxt.slave_addr = nv_addr_word_in[mrcr_pkg::ADDRW_ADDR_LSB +: 8];
         link_nxt.parity     = nv_addr_word_in[mrcr_pkg::ADDRW_PAR_LSB +: 2];
         link_nxt.stop_two   = nv_addr_word_in[mrcr_pkg::ADDRW_STOP_BIT];
         link_nxt.baud_code  = nv_baud_in;
      end
      else
      begin
         // switches can express up to 63; values above 62 saturate to 62
         link_nxt.slave_addr = (sw_addr > mrcr_pkg::SW_ADDR_MAX) ?
                               mrcr_pkg::SW_ADDR_MAX : sw_addr;
         link_nxt.parity     = mrcr_pkg::PAR_NONE;
         link_nxt.stop_two   = 1'b0;
         case (sw_q_r[mrcr_pkg::SW_W-1:mrcr_pkg::SW_BAUD_LSB])
            2'h0:    link_nxt.baud_code = mrcr_pkg::BAUD_9600;
            2'h1:    link_nxt.baud_code = mrcr_pkg::BAUD_19200;
            2'h2:    link_nxt.baud_code = mrcr_pkg::BAUD_38400;
            default: link_nxt.baud_code = mrcr_pkg::BAUD_115200;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         link_r <= '{8'h01, mrcr_pkg::BAUD_9600, mrcr_pkg::PAR_NONE, 1'b0};
      else
         link_r <= link_nxt;
   end

   assign link_cfg_out = link_r;

   // power-up sequencer: wait for the pin to settle, then update or run
   mrcr_pkg::mrcr_state_e state_r, state_nxt;
   logic [1:0]            boot_cnt_r, boot_cnt_nxt;

   always_comb
   begin
      state_nxt    = state_r;
      boot_cnt_nxt = boot_cnt_r;
      case (state_r)
         mrcr_pkg::ST_BOOT:
         begin
            boot_cnt_nxt = boot_cnt_r + 2'h1;
            if (boot_cnt_r == mrcr_pkg::BOOT_SETTLE)
               state_nxt = fw_q_nxt ? mrcr_pkg::ST_UPDATE : mrcr_pkg::ST_RUN;
         end
         mrcr_pkg::ST_UPDATE:
            if (fw_done_in)
               state_nxt = mrcr_pkg::ST_RUN;
         mrcr_pkg::ST_RUN:
            state_nxt = mrcr_pkg::ST_RUN;
         default:
            state_nxt = mrcr_pkg::ST_BOOT;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_r    <= mrcr_pkg::ST_BOOT;
         boot_cnt_r <= 2'h0;
      end
      else
      begin
         state_r    <= state_nxt;
         boot_cnt_r <= boot_cnt_nxt;
      end
   end

   // the loader never touches the save path, so stored settings survive
   assign fw_update_out = (state_r == mrcr_pkg::ST_UPDATE);

   // register file, calendar and action latch
   logic [15:0]          log_r   [3];
   logic [15:0]          log_nxt [3];
   mrcr_pkg::mrcr_cal_s  cal_r, cal_nxt;
   mrcr_pkg::mrcr_cmd_s  cmd_r, cmd_nxt, act_r, act_nxt;
   logic [31:0]          sec_cnt_r, sec_cnt_nxt;
   logic                 tick;
   logic                 wr, rd_ok, hit;
   logic [15:0]          rdata;
   logic                 ack_nxt, err_nxt, go_nxt, go_r;
   logic [15:0]          rdata_nxt, rdata_r;
   logic                 ack_r, err_r;

   always_comb
   begin
      tick        = (sec_cnt_r == SEC_LAST);
      sec_cnt_nxt = tick ? 32'h0 : sec_cnt_r + 32'h1;
      cal_nxt     = cal_r;
      // calendar advance with rollover through month and year
      if (tick)
      begin
         cal_nxt.second = cal_r.second + 8'h01;
         if (cal_r.second == mrcr_pkg::MINSEC_MAX)
         begin
            cal_nxt.second = 8'h00;
            cal_nxt.minute = cal_r.minute + 8'h01;
            if (cal_r.minute == mrcr_pkg::MINSEC_MAX)
            begin
               cal_nxt.minute = 8'h00;
               cal_nxt.hour   = cal_r.hour + 8'h01;
               if (cal_r.hour == mrcr_pkg::HOUR_MAX)
               begin
                  cal_nxt.hour = 8'h00;
                  cal_nxt.day  = cal_r.day + 8'h01;
                  if (cal_r.day >= mrcr_days(cal_r.month, cal_r.year))
                  begin
                     cal_nxt.day   = 8'h01;
                     cal_nxt.month = cal_r.month + 8'h01;
                     if (cal_r.month >= mrcr_pkg::MONTH_MAX)
                     begin
                        cal_nxt.month = 8'h01;
                        cal_nxt.year  = (cal_r.year >= mrcr_pkg::YEAR_MAX) ?
                                        mrcr_pkg::YEAR_RST : cal_r.year + 16'h0001;
                     end
                  end
               end
            end
         end
      end

      // address decode; during a firmware update the port is refused
      hit   = 1'b1;
      rdata = 16'h0000;
      case (reg_addr_in)
         mrcr_pkg::ADDR_LOG6:     rdata = log_r[0];
         mrcr_pkg::ADDR_LOG7:     rdata = log_r[1];
         mrcr_pkg::ADDR_LOG8:     rdata = log_r[2];
         mrcr_pkg::ADDR_YEAR:     rdata = cal_r.year;
         mrcr_pkg::ADDR_MONTH:    rdata = {8'h00, cal_r.month};
         mrcr_pkg::ADDR_DAY:      rdata = {8'h00, cal_r.day};
         mrcr_pkg::ADDR_HOUR:     rdata = {8'h00, cal_r.hour};
         mrcr_pkg::ADDR_MINUTE:   rdata = {8'h00, cal_r.minute};
         mrcr_pkg::ADDR_SECOND:   rdata = {8'h00, cal_r.second};
         mrcr_pkg::ADDR_ACT_CODE: rdata = cmd_r.code;
         mrcr_pkg::ADDR_ACT_ARGA: rdata = cmd_r.arg_a;
         mrcr_pkg::ADDR_ACT_ARGB: rdata = cmd_r.arg_b;
         default:                 hit   = 1'b0;
      endcase
      rd_ok = reg_req_in && hit && (state_r == mrcr_pkg::ST_RUN);
      wr    = rd_ok && reg_we_in;

      for (int i = 0; i < 3; i++)
         log_nxt[i] = log_r[i];
      cmd_nxt = cmd_r;
      go_nxt  = 1'b0;
      // a write lands after the tick update, so a set time is never lost
      if (wr)
      begin
         case (reg_addr_in)
            mrcr_pkg::ADDR_LOG6:     log_nxt[0]     = reg_wdata_in;
            mrcr_pkg::ADDR_LOG7:     log_nxt[1]     = reg_wdata_in;
            mrcr_pkg::ADDR_LOG8:     log_nxt[2]     = reg_wdata_in;
            mrcr_pkg::ADDR_YEAR:     cal_nxt.year   = reg_wdata_in;
            mrcr_pkg::ADDR_MONTH:    cal_nxt.month  = reg_wdata_in[7:0];
            mrcr_pkg::ADDR_DAY:      cal_nxt.day    = reg_wdata_in[7:0];
            mrcr_pkg::ADDR_HOUR:     cal_nxt.hour   = reg_wdata_in[7:0];
            mrcr_pkg::ADDR_MINUTE:   cal_nxt.minute = reg_wdata_in[7:0];
            mrcr_pkg::ADDR_SECOND:   cal_nxt.second = reg_wdata_in[7:0];
            mrcr_pkg::ADDR_ACT_CODE:
            begin
               cmd_nxt.code = reg_wdata_in;
               go_nxt       = 1'b1;
            end
            mrcr_pkg::ADDR_ACT_ARGA: cmd_nxt.arg_a  = reg_wdata_in;
            mrcr_pkg::ADDR_ACT_ARGB: cmd_nxt.arg_b  = reg_wdata_in;
            default:                 go_nxt         = 1'b0;
         endcase
      end

      // arguments are snapshotted together with the code that runs
      act_nxt = go_r ? cmd_r : act_r;

      ack_nxt   = reg_req_in;
      err_nxt   = reg_req_in && !rd_ok;
      rdata_nxt = (reg_req_in && rd_ok && !reg_we_in) ? rdata : rdata_r;
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         for (int i = 0; i < 3; i++)
            log_r[i] <= mrcr_pkg::LOG_RST;
         cal_r     <= '{mrcr_pkg::YEAR_RST, mrcr_pkg::MONTH_RST, mrcr_pkg::DAY_RST,
                        mrcr_pkg::HMS_RST, mrcr_pkg::HMS_RST, mrcr_pkg::HMS_RST};
         cmd_r     <= '{mrcr_pkg::ACT_RST, mrcr_pkg::ACT_RST, mrcr_pkg::ACT_RST};
         act_r     <= '{mrcr_pkg::ACT_RST, mrcr_pkg::ACT_RST, mrcr_pkg::ACT_RST};
         sec_cnt_r <= 32'h0;
         go_r      <= 1'b0;
         ack_r     <= 1'b0;
         err_r     <= 1'b0;
         rdata_r   <= 16'h0000;
      end
      else
      begin
         for (int i = 0; i < 3; i++)
            log_r[i] <= log_nxt[i];
         cal_r     <= cal_nxt;
         cmd_r     <= cmd_nxt;
         act_r     <= act_nxt;
         sec_cnt_r <= sec_cnt_nxt;
         go_r      <= go_nxt;
         ack_r     <= ack_nxt;
         err_r     <= err_nxt;
         rdata_r   <= rdata_nxt;
      end
   end

   assign reg_ack_out   = ack_r;
   assign reg_err_out   = err_r;
   assign reg_rdata_out = rdata_r;
   assign act_arg_a_out = act_r.arg_a;
   assign act_arg_b_out = act_r.arg_b;

   // action strobes, in the same cycle as the snapshot; unknown codes do nothing
   logic rst_pl_r, save_pl_r, fact_pl_r;
   logic rst_pl_nxt, save_pl_nxt, fact_pl_nxt;

   always_comb
   begin
      rst_pl_nxt  = go_r && (cmd_r.code == mrcr_pkg::ACT_RESET);
      save_pl_nxt = go_r && (cmd_r.code == mrcr_pkg::ACT_SAVE);
      fact_pl_nxt = go_r && (cmd_r.code == mrcr_pkg::ACT_FACTORY);
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rst_pl_r  <= 1'b0;
         save_pl_r <= 1'b0;
         fact_pl_r <= 1'b0;
      end
      else
      begin
         rst_pl_r  <= rst_pl_nxt;
         save_pl_r <= save_pl_nxt;
         fact_pl_r <= fact_pl_nxt;
      end
   end

   assign reset_req_out   = rst_pl_r;
   assign save_cfg_out    = save_pl_r;
   assign factory_cfg_out = fact_pl_r;

   // front lamps; activity lamps are stretched so short frames stay visible
   logic [31:0] flash_cnt_r, flash_cnt_nxt, rx_hold_r, rx_hold_nxt, tx_hold_r, tx_hold_nxt;
   logic        flash_r, flash_nxt, fail_r, fail_nxt, dout_r, dout_nxt;

   always_comb
   begin
      flash_cnt_nxt = (flash_cnt_r == FLASH_LAST) ? 32'h0 : flash_cnt_r + 32'h1;
      flash_nxt     = (flash_cnt_r == FLASH_LAST) ? !flash_r : flash_r;
      rx_hold_nxt   = rx_frame_in ? HOLD_LAST :
                      (rx_hold_r != 32'h0) ? rx_hold_r - 32'h1 : 32'h0;
      tx_hold_nxt   = tx_frame_in ? HOLD_LAST :
                      (tx_hold_r != 32'h0) ? tx_hold_r - 32'h1 : 32'h0;
      fail_nxt      = fw_update_out ? flash_r : (|fail_events_in);
      dout_nxt      = relay_on_in;
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         flash_cnt_r <= 32'h0;
         flash_r     <= 1'b0;
         rx_hold_r   <= 32'h0;
         tx_hold_r   <= 32'h0;
         fail_r      <= 1'b0;
         dout_r      <= 1'b0;
      end
      else
      begin
         flash_cnt_r <= flash_cnt_nxt;
         flash_r     <= flash_nxt;
         rx_hold_r   <= rx_hold_nxt;
         tx_hold_r   <= tx_hold_nxt;
         fail_r      <= fail_nxt;
         dout_r      <= dout_nxt;
      end
   end

   assign led_power_out = 1'b1;                     // logic alive means supply present
   assign led_fail_out  = fail_r;
   assign led_rx_out    = (rx_hold_r != 32'h0);
   assign led_tx_out    = (tx_hold_r != 32'h0);
   assign led_dout_out  = dout_r;
endmodule : mrcr_regs

// File: logic/mrcr_pkg.sv
package mrcr_pkg;
   // holding-register addresses, kept as the decimal Modbus numbers in hex
   localparam logic [15:0] ADDR_LOG6     = 16'h9CC1;
   localparam logic [15:0] ADDR_LOG7     = 16'h9CC2;
   localparam logic [15:0] ADDR_LOG8     = 16'h9CC3;
   localparam logic [15:0] ADDR_YEAR     = 16'hA029;
   localparam logic [15:0] ADDR_MONTH    = 16'hA02A;
   localparam logic [15:0] ADDR_DAY      = 16'hA02B;
   localparam logic [15:0] ADDR_HOUR     = 16'hA02C;
   localparam logic [15:0] ADDR_MINUTE   = 16'hA02D;
   localparam logic [15:0] ADDR_SECOND   = 16'hA02E;
   localparam logic [15:0] ADDR_ACT_CODE = 16'hA411;
   localparam logic [15:0] ADDR_ACT_ARGA = 16'hA412;
   localparam logic [15:0] ADDR_ACT_ARGB = 16'hA413;

   // action codes
   localparam logic [15:0] ACT_RESET     = 16'h0001;
   localparam logic [15:0] ACT_SAVE      = 16'h0002;
   localparam logic [15:0] ACT_FACTORY   = 16'h0003;

   // reset values and limits
   localparam logic [15:0] LOG_RST       = 16'h0000;
   localparam logic [15:0] YEAR_RST      = 16'h07D0;   // 2000
   localparam logic [15:0] YEAR_MAX      = 16'h0833;   // 2099
   localparam logic [7:0]  MONTH_RST     = 8'h01;
   localparam logic [7:0]  DAY_RST       = 8'h01;
   localparam logic [7:0]  HMS_RST       = 8'h00;
   localparam logic [7:0]  MONTH_MAX     = 8'h0C;
   localparam logic [7:0]  HOUR_MAX      = 8'h17;
   localparam logic [7:0]  MINSEC_MAX    = 8'h3B;
   localparam logic [15:0] ACT_RST       = 16'h0000;

   // stored address word layout
   localparam int          ADDRW_ADDR_LSB = 8;
   localparam int          ADDRW_PAR_LSB  = 0;
   localparam int          ADDRW_STOP_BIT = 2;

   // switch layout: low six bits address, top two bits baud choice
   localparam int          SW_W          = 8;
   localparam int          SW_BAUD_LSB   = 6;
   localparam logic [7:0]  SW_ADDR_MAX   = 8'h3E;   // 62
   localparam logic [2:0]  BAUD_9600     = 3'h3;
   localparam logic [2:0]  BAUD_19200    = 3'h4;
   localparam logic [2:0]  BAUD_38400    = 3'h5;
   localparam logic [2:0]  BAUD_115200   = 3'h7;
   localparam logic [1:0]  PAR_NONE      = 2'h0;

   // timing
   localparam longint      CLK_HZ        = 100_000_000;
   localparam longint      TICK_S        = 1;
   localparam longint      FLASH_MS      = 250;
   localparam longint      ACT_HOLD_MS   = 30;
   localparam longint      SEC_CYC       = CLK_HZ * TICK_S;
   localparam longint      FLASH_CYC     = (CLK_HZ / 1000) * FLASH_MS;
   localparam longint      ACT_HOLD_CYC  = (CLK_HZ / 1000) * ACT_HOLD_MS;
   localparam logic [1:0]  BOOT_SETTLE   = 2'h3;

   typedef enum logic [2:0]
   {
      ST_BOOT   = 3'b001,
      ST_UPDATE = 3'b010,
      ST_RUN    = 3'b100
   } mrcr_state_e;

   typedef struct packed
   {
      logic [15:0] year;
      logic [7:0]  month;
      logic [7:0]  day;
      logic [7:0]  hour;
      logic [7:0]  minute;
      logic [7:0]  second;
   } mrcr_cal_s;

   typedef struct packed
   {
      logic [15:0] code;
      logic [15:0] arg_a;
      logic [15:0] arg_b;
   } mrcr_cmd_s;

   typedef struct packed
   {
      logic [7:0] slave_addr;
      logic [2:0] baud_code;
      logic [1:0] parity;
      logic       stop_two;
   } mrcr_link_s;
endpackage : mrcr_pkg

// File: verif/mrcr_regs_asserts.sv
`timescale 1ns/1ns
module mrcr_regs_asserts (
   input wire logic        clk_in,         // clock
   input wire logic        rst_n_in,       // reset
   input wire logic        reg_req_in,     // request
   input wire logic        reg_we_in,      // write
   input wire logic [15:0] reg_addr_in,    // address
   input wire logic [15:0] reg_wdata_in,   // data
   input wire logic        reg_ack_out,    // answer
   input wire logic        reg_err_out,    // refusal
   input wire logic        save_cfg_out,   // save pulse
   input wire logic        fw_update_out,  // updating
   input wire logic [7:0]  fail_events_in, // failures
   input wire logic        led_fail_out,   // fail lamp
   input wire logic        relay_on_in,    // relay
   input wire logic        led_dout_out    // output lamp
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // an accepted save code gives exactly one save pulse
   property p_save;
      (reg_req_in && reg_we_in && reg_addr_in == mrcr_pkg::ADDR_ACT_CODE
         && reg_wdata_in == mrcr_pkg::ACT_SAVE) ##1 (reg_ack_out && !reg_err_out)
         |=> save_cfg_out ##1 !save_cfg_out;
   endproperty
   a_ack_next: assert property (reg_req_in |=> reg_ack_out)
      else $error("request not answered");
   a_ack_cause: assert property (reg_ack_out |-> $past(reg_req_in))
      else $error("answer without request");
   a_err_with_ack: assert property (reg_err_out |-> reg_ack_out)
      else $error("refusal without answer");
   a_err_unmapped: assert property (reg_req_in && !(reg_addr_in inside
      {[16'h9CC1:16'h9CC3], [16'hA029:16'hA02E], [16'hA411:16'hA413]}) |=> reg_err_out)
      else $error("unmapped address accepted");
   a_save_code: assert property (p_save)
      else $error("save code gave no single pulse");
   a_save_cause: assert property (save_cfg_out |-> $past(reg_ack_out))
      else $error("save pulse without accepted write");
   a_fail_follow: assert property (!fw_update_out && !$past(fw_update_out)
      && $past(rst_n_in) |-> led_fail_out == (|$past(fail_events_in)))
      else $error("fail lamp not tracking failures");
   a_dout_follow: assert property ($past(rst_n_in)
      |-> led_dout_out == $past(relay_on_in))
      else $error("output lamp not tracking relay");
   c_save: cover property (save_cfg_out);
   c_refused: cover property (reg_ack_out && reg_err_out);
   c_flash: cover property (fw_update_out && led_fail_out);
endmodule : mrcr_regs_asserts
bind mrcr_regs mrcr_regs_asserts mrcr_regs_asserts_i (.clk_in, .rst_n_in, .reg_req_in,
   .reg_we_in, .reg_addr_in, .reg_wdata_in, .reg_ack_out, .reg_err_out, .save_cfg_out,
   .fw_update_out, .fail_events_in, .led_fail_out, .relay_on_in, .led_dout_out);

// File: verif/mrcr_master.sv
`timescale 1ns/1ns
module mrcr_master (
   input  wire logic        clk_in,   // clock
   input  wire logic        ack_in,   // answer
   input  wire logic        err_in,   // refusal
   input  wire logic [15:0] rdata_in, // read data
   output logic             req_out,  // request
   output logic             we_out,   // write
   output logic [15:0]      addr_out, // address
   output logic [15:0]      data_out  // write data
);
   initial
   begin
      req_out = 1'b0;
      we_out = 1'b0;
      addr_out = 16'h0000;
      data_out = 16'h0000;
   end
   // one access; released address and data lines show the inverse so stale values never pass
   task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
                         output logic [15:0] r, output logic e);
      @(posedge clk_in);
      req_out <= 1'b1;
      we_out <= w;
      addr_out <= a;
      data_out <= d;
      @(posedge clk_in);
      req_out <= 1'b0;
      addr_out <= ~a;
      data_out <= ~d;
      #1;
      e = (ack_in === 1'b1) ? err_in : 1'b1;
      r = rdata_in;
   endtask : access
endmodule : mrcr_master

// File: verif/mrcr_regs_bench.sv
`timescale 1ns/1ns
module mrcr_regs_bench;
   logic        clk_in = 1'b0, rst_n_in = 1'b0, fw_present_in = 1'b1, fw_done_in = 1'b0;
   logic        rx_frame_in = 1'b0, tx_frame_in = 1'b0, relay_on_in = 1'b0, got_err;
   logic        reg_req_in, reg_we_in, reg_ack_out, reg_err_out, fw_update_out;
   logic        reset_req_out, save_cfg_out, factory_cfg_out, led_power_out, led_fail_out;
   logic        led_rx_out, led_tx_out, led_dout_out;
   logic [15:0] reg_addr_in, reg_wdata_in, reg_rdata_out, act_arg_a_out, act_arg_b_out, got;
   logic [15:0] nv_addr_word_in = 16'h0100;
   logic [7:0]  dip_sw_in = 8'h00, fail_events_in = 8'h00;
   logic [2:0]  nv_baud_in = 3'h3;
   mrcr_pkg::mrcr_link_s link_cfg_out;
   int          bad_count = 0, n_checks = 0, cyc = 0;
   always #5 clk_in = ~clk_in;
   // short counts keep the run brief
   mrcr_regs #(.SEC_CYCLES(20), .FLASH_CYCLES(4), .HOLD_CYCLES(5)) mrcr_regs_i (.clk_in,
      .rst_n_in, .reg_req_in, .reg_we_in, .reg_addr_in, .reg_wdata_in, .reg_ack_out,
      .reg_err_out, .reg_rdata_out, .dip_sw_in, .nv_addr_word_in, .nv_baud_in, .link_cfg_out,
      .fw_present_in, .fw_done_in, .fw_update_out, .reset_req_out, .save_cfg_out,
      .factory_cfg_out, .act_arg_a_out, .act_arg_b_out, .rx_frame_in, .tx_frame_in,
      .fail_events_in, .relay_on_in, .led_power_out, .led_fail_out, .led_rx_out, .led_tx_out,
      .led_dout_out);
   mrcr_master mrcr_master_i (.clk_in(clk_in), .ack_in(reg_ack_out), .err_in(reg_err_out),
      .rdata_in(reg_rdata_out), .req_out(reg_req_in), .we_out(reg_we_in),
      .addr_out(reg_addr_in), .data_out(reg_wdata_in));
   task automatic check(input logic [15:0] g, input logic [15:0] e, input string what);
      n_checks++;
      if (g !== e)
      begin
         $display("wrong value at %0t: %s gave %h not %h", $time, what, g, e);
         bad_count++;
      end
   endtask : check
   task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                      input logic e_err, input logic [15:0] e_rd);
      mrcr_master_i.access(w, a, d, got, got_err);
      check({15'h0000, got_err}, {15'h0000, e_err}, "refusal");
      if (!w && !e_err)
         check(got, e_rd, "read data");
   endtask : acc
   task automatic settle(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : settle
   task automatic t_update;
      logic lamp;
      settle(8);
      check({15'h0000, fw_update_out}, 16'h0001, "update");
      acc(1'b0, mrcr_pkg::ADDR_LOG6, 16'h0000, 1'b1, 16'h0000);
      lamp = led_fail_out;
      settle(4);
      check({15'h0000, led_fail_out}, {15'h0000, ~lamp}, "flash");
      @(posedge clk_in);
      fw_present_in <= 1'b0;
      fw_done_in <= 1'b1;
      @(posedge clk_in);
      fw_done_in <= 1'b0;
      settle(3);
      check({15'h0000, fw_update_out}, 16'h0000, "update end");
      check({2'h0, link_cfg_out}, 16'h0058, "kept config");
   endtask : t_update
   task automatic t_regs;
      for (int i = 0; i < 3; i++)
      begin
         acc(1'b0, mrcr_pkg::ADDR_LOG6 + 16'(i), 16'h0000, 1'b0, 16'h0000);
         acc(1'b1, mrcr_pkg::ADDR_LOG6 + 16'(i), 16'hA5C0 + 16'(i), 1'b0, 16'h0000);
         acc(1'b0, mrcr_pkg::ADDR_LOG6 + 16'(i), 16'h0000, 1'b0, 16'hA5C0 + 16'(i));
      end
      acc(1'b0, mrcr_pkg::ADDR_YEAR, 16'h0000, 1'b0, 16'h07D0);
      acc(1'b1, 16'hA410, 16'h0001, 1'b1, 16'h0000);
      // minute and second at 59 roll the hour on the next tick
      acc(1'b1, mrcr_pkg::ADDR_MINUTE, 16'h003B, 1'b0, 16'h0000);
      acc(1'b1, mrcr_pkg::ADDR_SECOND, 16'h003B, 1'b0, 16'h0000);
      settle(22);
      acc(1'b0, mrcr_pkg::ADDR_MINUTE, 16'h0000, 1'b0, 16'h0000);
      acc(1'b0, mrcr_pkg::ADDR_HOUR, 16'h0000, 1'b0, 16'h0001);
   endtask : t_regs
   task automatic t_action;
      acc(1'b1, mrcr_pkg::ADDR_ACT_ARGA, 16'h1234, 1'b0, 16'h0000);
      acc(1'b1, mrcr_pkg::ADDR_ACT_ARGB, 16'hABCD, 1'b0, 16'h0000);
      for (int c = 1; c < 5; c++)
      begin
         acc(1'b1, mrcr_pkg::ADDR_ACT_CODE, 16'(c), 1'b0, 16'h0000);
         settle(1);
         check({13'h0000, reset_req_out, save_cfg_out, factory_cfg_out}, 16'h0008 >> c, "pulse");
         check(act_arg_a_out ^ act_arg_b_out, 16'hB9F9, "arguments");
      end
   endtask : t_action
   task automatic t_link(input logic [7:0] sw, input logic [15:0] nv, input logic [15:0] e);
      @(posedge clk_in);
      dip_sw_in <= sw;
      nv_addr_word_in <= nv;
      nv_baud_in <= 3'h6;
      settle(10);
      check({2'h0, link_cfg_out}, e, "link choice");
   endtask : t_link
   task automatic t_leds;
      @(posedge clk_in);
      {fail_events_in, relay_on_in, rx_frame_in, tx_frame_in} <= {8'h04, 3'b111};
      @(posedge clk_in);
      {rx_frame_in, tx_frame_in, fail_events_in, relay_on_in} <= 11'h000;
      #1;
      check({led_power_out, led_fail_out, led_dout_out, led_rx_out, led_tx_out}, 16'h001F, "lamps on");
      settle(6);
      check({led_power_out, led_fail_out, led_dout_out, led_rx_out, led_tx_out}, 16'h0010, "lamps off");
   endtask : t_leds
   task automatic give_verdict;
      if (bad_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict
   initial
   begin
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_update();
      t_regs();
      t_action();
      t_link(8'h45, 16'hC806, 16'h0160);
      t_link(8'hFF, 16'hC806, 16'h0FB8);
      t_link(8'h00, 16'hC806, 16'h3235);
      t_leds();
      give_verdict();
   end
   // a hang still ends the run with a verdict
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         bad_count++;
         give_verdict();
      end
   end
endmodule : mrcr_regs_bench
